// ---- common/asb_pkg.sv ----
// Purpose: constants for the status / bank-select register and timer config
// Assumes: one core clock, instruction results arrive as one-cycle strobes
// Notes: offsets are the low seven address bits only; the option bank bit is checked in the status block
package asb_pkg;
	localparam logic [6:0] STATUS_OFS = 7'h03;
	localparam logic [6:0] OPTION_OFS = 7'h01;
	localparam int BANK_BYTES = 128;
	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam logic [7:0] OPTION_RST = 8'hff;
	localparam int B_IRP = 7;
	localparam int B_RPH = 6;
	localparam int B_RPL = 5;
	localparam int B_EXP = 4;
	localparam int B_SLP = 3;
	localparam int B_Z = 2;
	localparam int B_DC = 1;
	localparam int B_C = 0;
	localparam int O_PSA = 3;
	localparam int PS_W = 8;

	typedef enum logic [3:0] {
		ASB_NOP = 4'h0,
		ASB_ADD = 4'h1,
		ASB_SUB = 4'h2,
		ASB_AND = 4'h3,
		ASB_IOR = 4'h4,
		ASB_XOR = 4'h5,
		ASB_RLF = 4'h6,
		ASB_RRF = 4'h7,
		ASB_FILE_CLEAR_OP = 4'h8,
		ASB_BCF = 4'h9,
		ASB_BSF = 4'ha,
		ASB_SWAP = 4'hb,
		ASB_MOVE_W_TO_FILE_OP = 4'hc,
		ASB_CLRWDT = 4'hd,
		ASB_SLEEP = 4'he
	} asb_op_t;
endpackage

// ---- verilog/asb_flag_alu.sv ----
// Purpose: result and flag logic of one instruction
// Assumes: purely combinational
// Notes: update flags tell which of z, dc, c the instruction owns
`timescale 1ns/1ps
`default_nettype none
module asb_flag_alu (
	input wire asb_pkg::asb_op_t op_i,
	input wire logic [7:0] a_i,
	input wire logic [7:0] w_i,
	input wire logic [2:0] bit_i,
	input wire logic c_i,
	output logic [7:0] res_o,
	output logic z_o,
	output logic dc_o,
	output logic c_o,
	output logic upd_z_o,
	output logic upd_dc_o,
	output logic upd_c_o
);
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] addend;

	always_comb begin
		// subtraction adds the two's complement of w
		addend = (op_i == asb_pkg::ASB_SUB) ? ~w_i : w_i;
		sum = {1'b0, a_i} + {1'b0, addend} +
			{8'h00, op_i == asb_pkg::ASB_SUB};
		nib = {1'b0, a_i[3:0]} + {1'b0, addend[3:0]} +
			{4'h0, op_i == asb_pkg::ASB_SUB};
		res_o = a_i;
		c_o = c_i;
		dc_o = 1'b0;
		upd_z_o = 1'b0;
		upd_dc_o = 1'b0;
		upd_c_o = 1'b0;
		unique case (op_i)
			asb_pkg::ASB_ADD, asb_pkg::ASB_SUB: begin
				res_o = sum[7:0];
				c_o = sum[8];
				dc_o = nib[4];
				upd_z_o = 1'b1;
				upd_dc_o = 1'b1;
				upd_c_o = 1'b1;
			end
			asb_pkg::ASB_AND: begin
				res_o = a_i & w_i;
				upd_z_o = 1'b1;
			end
			asb_pkg::ASB_IOR: begin
				res_o = a_i | w_i;
				upd_z_o = 1'b1;
			end
			asb_pkg::ASB_XOR: begin
				res_o = a_i ^ w_i;
				upd_z_o = 1'b1;
			end
			asb_pkg::ASB_RLF: begin
				res_o = {a_i[6:0], c_i};
				c_o = a_i[7];
				upd_c_o = 1'b1;
			end
			asb_pkg::ASB_RRF: begin
				res_o = {c_i, a_i[7:1]};
				c_o = a_i[0];
				upd_c_o = 1'b1;
			end
			asb_pkg::ASB_FILE_CLEAR_OP: begin
				res_o = 8'h00;
				upd_z_o = 1'b1;
			end
			// these four never own a flag
			asb_pkg::ASB_BCF: res_o = a_i & ~(8'h01 << bit_i);
			asb_pkg::ASB_BSF: res_o = a_i | (8'h01 << bit_i);
			asb_pkg::ASB_SWAP: res_o = {a_i[3:0], a_i[7:4]};
			asb_pkg::ASB_MOVE_W_TO_FILE_OP: res_o = w_i;
			default: res_o = a_i;
		endcase
		z_o = (res_o == 8'h00);
	end
endmodule
`default_nettype wire

// ---- verilog/asb_status_bank.sv ----
// Purpose: status / bank-select register, timer config and shared prescaler
// Assumes: all inputs come from core logic on clk_i
// Notes: one instruction per exe_i strobe; results land one edge later
`timescale 1ns/1ps
`default_nettype none
module asb_status_bank (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic exe_i,
	input wire asb_pkg::asb_op_t op_i,
	input wire logic [8:0] addr_i,
	input wire logic to_file_i,
	input wire logic [7:0] w_i,
	input wire logic [7:0] file_rd_i,
	input wire logic [2:0] bit_i,
	input wire logic [7:0] fsr_i,
	input wire logic wdt_timeout_i,
	input wire logic tmr_tick_i,
	input wire logic wdt_tick_i,
	output logic [7:0] result_o,
	output logic file_we_o,
	output logic w_we_o,
	output logic [7:0] status_o,
	output logic [7:0] option_o,
	output logic [8:0] direct_addr_o,
	output logic [8:0] indirect_addr_o,
	output logic tmr_inc_o,
	output logic wdt_inc_o
);
	logic [7:0] status_ff;
	logic [7:0] nxt_status;
	logic [7:0] option_ff;
	logic [7:0] result_ff;
	logic file_we_ff;
	logic w_we_ff;
	logic [asb_pkg::PS_W-1:0] ps_cnt_ff;
	logic tmr_inc_ff;
	logic wdt_inc_ff;
	logic is_status;
	logic is_option;
	logic [7:0] operand;
	logic [7:0] alu_res;
	logic alu_z;
	logic alu_dc;
	logic alu_c;
	logic upd_z;
	logic upd_dc;
	logic upd_c;
	logic psa;
	logic [asb_pkg::PS_W-1:0] tmr_mask;
	logic [asb_pkg::PS_W-1:0] wdt_mask;
	logic ps_tick;

	// status ignores bank bits: same register in every bank; option also needs addr_i[7]
	assign is_status = (addr_i[6:0] == asb_pkg::STATUS_OFS);
	assign is_option = addr_i[7] && (addr_i[6:0] == asb_pkg::OPTION_OFS);
	assign operand = is_status ? status_ff :
		(is_option ? option_ff : file_rd_i);

	asb_flag_alu u_alu (
		.op_i(op_i),
		.a_i(operand),
		.w_i(w_i),
		.bit_i(bit_i),
		.c_i(status_ff[asb_pkg::B_C]),
		.res_o(alu_res),
		.z_o(alu_z),
		.dc_o(alu_dc),
		.c_o(alu_c),
		.upd_z_o(upd_z),
		.upd_dc_o(upd_dc),
		.upd_c_o(upd_c)
	);

	always_comb begin
		nxt_status = status_ff;
		if (exe_i && to_file_i && is_status) begin
			nxt_status[7:5] = alu_res[7:5];
			// flag bits take data only if the op does not own them
			if (!upd_z)
				nxt_status[asb_pkg::B_Z] = alu_res[asb_pkg::B_Z];
			// a clear leaves dc and c as they were
			if (!upd_dc && op_i != asb_pkg::ASB_FILE_CLEAR_OP)
				nxt_status[asb_pkg::B_DC] = alu_res[asb_pkg::B_DC];
			if (!upd_c && op_i != asb_pkg::ASB_FILE_CLEAR_OP)
				nxt_status[asb_pkg::B_C] = alu_res[asb_pkg::B_C];
		end
		if (exe_i) begin
			if (upd_z)
				nxt_status[asb_pkg::B_Z] = alu_z;
			if (upd_dc)
				nxt_status[asb_pkg::B_DC] = alu_dc;
			if (upd_c)
				nxt_status[asb_pkg::B_C] = alu_c;
			if (op_i == asb_pkg::ASB_CLRWDT) begin
				nxt_status[asb_pkg::B_EXP] = 1'b1;
				nxt_status[asb_pkg::B_SLP] = 1'b1;
			end
			if (op_i == asb_pkg::ASB_SLEEP) begin
				nxt_status[asb_pkg::B_EXP] = 1'b1;
				nxt_status[asb_pkg::B_SLP] = 1'b0;
			end
		end
		// timeout wins over a watchdog clear in the same cycle
		if (wdt_timeout_i)
			nxt_status[asb_pkg::B_EXP] = 1'b0;
	end

	// expiry and sleep-entry bits only move via nxt_status above
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			status_ff <= asb_pkg::STATUS_RST;
		else
			status_ff <= nxt_status;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			option_ff <= asb_pkg::OPTION_RST;
		else if (exe_i && to_file_i && is_option)
			option_ff <= alu_res;
	end

	// instruction result to the file or to w
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			result_ff <= 8'h00;
			file_we_ff <= 1'b0;
			w_we_ff <= 1'b0;
		end else begin
			file_we_ff <= 1'b0;
			w_we_ff <= 1'b0;
			if (exe_i && op_i != asb_pkg::ASB_NOP &&
				op_i != asb_pkg::ASB_CLRWDT &&
				op_i != asb_pkg::ASB_SLEEP) begin
				result_ff <= alu_res;
				file_we_ff <= to_file_i && !is_status && !is_option;
				w_we_ff <= !to_file_i;
			end
		end
	end

	// shared prescaler
	assign psa = option_ff[asb_pkg::O_PSA];
	assign tmr_mask = (asb_pkg::PS_W'(2) << option_ff[2:0]) - 1'b1;
	assign wdt_mask = (asb_pkg::PS_W'(1) << option_ff[2:0]) - 1'b1;
	assign ps_tick = psa ? wdt_tick_i : tmr_tick_i;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			ps_cnt_ff <= '0;
		else if (ps_tick)
			ps_cnt_ff <= ps_cnt_ff + 1'b1;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tmr_inc_ff <= 1'b0;
			wdt_inc_ff <= 1'b0;
		end else begin
			// prescaler on watchdog: timer sees every tick
			tmr_inc_ff <= tmr_tick_i &&
				(psa || (ps_cnt_ff & tmr_mask) == tmr_mask);
			wdt_inc_ff <= wdt_tick_i &&
				(!psa || (ps_cnt_ff & wdt_mask) == wdt_mask);
		end
	end

	assign result_o = result_ff;
	assign file_we_o = file_we_ff;
	assign w_we_o = w_we_ff;
	assign status_o = status_ff;
	assign option_o = option_ff;
	assign direct_addr_o = {status_ff[asb_pkg::B_RPH:asb_pkg::B_RPL],
		addr_i[6:0]};
	assign indirect_addr_o = {status_ff[asb_pkg::B_IRP], fsr_i};
	assign tmr_inc_o = tmr_inc_ff;
	assign wdt_inc_o = wdt_inc_ff;

	// checks
	logic wr_st;
	assign wr_st = exe_i && to_file_i && is_status;

	sequence clr_status_s;
		exe_i && to_file_i && is_status && op_i == asb_pkg::ASB_FILE_CLEAR_OP &&
			!wdt_timeout_i;
	endsequence

	clr_status_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		clr_status_s |=> status_ff[7:5] == 3'b000 &&
			status_ff[asb_pkg::B_Z] && $stable(status_ff[4:3]) &&
			status_ff[1:0] == $past(status_ff[1:0]))
		else $error("clear of status wrong");

	ro_bits_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_st && op_i == asb_pkg::ASB_MOVE_W_TO_FILE_OP && !wdt_timeout_i
		|=> status_ff[4:3] == $past(status_ff[4:3]))
		else $error("read-only status bits changed by write");

	flag_block_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_st && op_i == asb_pkg::ASB_ADD
		|=> status_ff[asb_pkg::B_C] == $past(alu_c) &&
			status_ff[asb_pkg::B_Z] == $past(alu_z))
		else $error("flag write not blocked");

	keep_flags_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		exe_i && !is_status && (op_i == asb_pkg::ASB_BSF ||
			op_i == asb_pkg::ASB_SWAP) |=> $stable(status_ff[2:0]))
		else $error("bit op touched flags");

	zero_flag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		exe_i && !is_status && op_i == asb_pkg::ASB_XOR
		|=> status_ff[asb_pkg::B_Z] == ($past(operand) == $past(w_i)))
		else $error("zero flag wrong");

	sub_carry_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		exe_i && !is_status && op_i == asb_pkg::ASB_SUB
		|=> status_ff[asb_pkg::B_C] == ($past(operand) >= $past(w_i)))
		else $error("borrow polarity wrong");

	rotate_c_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		exe_i && !is_status && op_i == asb_pkg::ASB_RLF
		|=> status_ff[asb_pkg::B_C] == $past(operand[7]))
		else $error("rotate carry wrong");

	timeout_bit_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wdt_timeout_i |=> !status_ff[asb_pkg::B_EXP])
		else $error("expiry bit not cleared");

	bank_alias_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		exe_i && to_file_i && op_i == asb_pkg::ASB_MOVE_W_TO_FILE_OP &&
			addr_i[6:0] == asb_pkg::STATUS_OFS
		|=> status_ff[7:5] == $past(w_i[7:5]) && !file_we_o)
		else $error("status alias differs");

	one_to_one_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		psa && tmr_tick_i |=> tmr_inc_o)
		else $error("timer not 1:1 with prescaler on watchdog");
endmodule
`default_nettype wire

// ---- verif/asb_status_bank_tb.sv ----
// Purpose: self-checking bench for the status / bank-select register
// Assumes: one instruction per cycle, outputs checked 1 ns after the edge
// Notes: a reference model tracks status, result and timer pulses
`timescale 1ns/1ps
`default_nettype none
module asb_status_bank_tb;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic exe_i = 1'b0;
	asb_pkg::asb_op_t op_i = asb_pkg::ASB_NOP;
	logic [8:0] addr_i = 9'h000;
	logic to_file_i = 1'b0;
	logic [7:0] w_i = 8'h00;
	logic [7:0] file_rd_i = 8'h00;
	logic [2:0] bit_i = 3'h0;
	logic [7:0] fsr_i = 8'h00;
	logic wdt_timeout_i = 1'b0;
	logic tmr_tick_i = 1'b0;
	logic wdt_tick_i = 1'b0;
	logic [7:0] result_o, status_o, option_o;
	logic file_we_o, w_we_o, tmr_inc_o, wdt_inc_o;
	logic [8:0] direct_addr_o, indirect_addr_o;
	int failures = 0;
	int total_checks = 0;
	logic [31:0] seed = 32'h3024847d;
	logic [7:0] es = 8'h18;
	logic [7:0] er = 8'h00;
	logic rv = 1'b0;
	logic tk = 1'b0;
	logic wk = 1'b0;
	logic ps = 1'b1;
	logic pc = 1'b1;
	logic fe = 1'b0;
	logic we = 1'b0;
	logic pe = 1'b0;
	logic [2:0] rt = 3'h7;
	int pn = 0;

	always #50 clk_i = ~clk_i;

	asb_status_bank DUT (.clk_i(clk_i), .rstn_i(rstn_i), .exe_i(exe_i),
		.op_i(op_i), .addr_i(addr_i), .to_file_i(to_file_i), .w_i(w_i),
		.file_rd_i(file_rd_i), .bit_i(bit_i), .fsr_i(fsr_i),
		.wdt_timeout_i(wdt_timeout_i), .tmr_tick_i(tmr_tick_i),
		.wdt_tick_i(wdt_tick_i), .result_o(result_o), .file_we_o(file_we_o),
		.w_we_o(w_we_o), .status_o(status_o), .option_o(option_o),
		.direct_addr_o(direct_addr_o), .indirect_addr_o(indirect_addr_o),
		.tmr_inc_o(tmr_inc_o), .wdt_inc_o(wdt_inc_o));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
	endfunction

	// returns {own z, own dc, own c, z, dc, c, result}
	function automatic logic [13:0] alu(input asb_pkg::asb_op_t op,
		input logic [7:0] a, input logic [7:0] w, input logic [2:0] b,
		input logic c);
		logic sb;
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] r;
		logic [2:0] u;
		logic cy;
		sb = (op == asb_pkg::ASB_SUB);
		s = {1'b0, a} + {1'b0, sb ? ~w : w} + {8'h00, sb};
		h = {1'b0, a[3:0]} + {1'b0, sb ? ~w[3:0] : w[3:0]} + {4'h0, sb};
		case (op)
		asb_pkg::ASB_ADD, asb_pkg::ASB_SUB: r = s[7:0];
		asb_pkg::ASB_AND: r = a & w;
		asb_pkg::ASB_IOR: r = a | w;
		asb_pkg::ASB_XOR: r = a ^ w;
		asb_pkg::ASB_RLF: r = {a[6:0], c};
		asb_pkg::ASB_RRF: r = {c, a[7:1]};
		asb_pkg::ASB_BCF: r = a & ~(8'h01 << b);
		asb_pkg::ASB_BSF: r = a | (8'h01 << b);
		asb_pkg::ASB_SWAP: r = {a[3:0], a[7:4]};
		asb_pkg::ASB_MOVE_W_TO_FILE_OP: r = w;
		default: r = 8'h00;
		endcase
		u = sb || op == asb_pkg::ASB_ADD ? 3'b111 : 3'b000;
		if (op inside {[asb_pkg::ASB_AND:asb_pkg::ASB_XOR], asb_pkg::ASB_FILE_CLEAR_OP})
			u = 3'b100;
		if (op inside {asb_pkg::ASB_RLF, asb_pkg::ASB_RRF})
			u = 3'b001;
		cy = op == asb_pkg::ASB_RLF ? a[7] : op == asb_pkg::ASB_RRF ? a[0] : s[8];
		return {u, r == 8'h00, h[4], cy, r};
	endfunction

	task automatic chk(input string nm, input logic [8:0] seen,
		input logic [8:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic step(input asb_pkg::asb_op_t op, input logic [8:0] ad,
		input logic tf, input logic [7:0] w, input logic [7:0] fr,
		input logic [2:0] b, input logic to);
		logic [13:0] v;
		logic [7:0] n;
		seed = lfsr(seed);
		@(posedge clk_i);
		exe_i <= 1'b1;
		op_i <= op;
		addr_i <= ad;
		to_file_i <= tf;
		w_i <= w;
		file_rd_i <= fr;
		bit_i <= b;
		fsr_i <= seed[15:8];
		wdt_timeout_i <= to;
		tmr_tick_i <= seed[16];
		wdt_tick_i <= seed[17];
		#1;
		chk("status", {1'b0, status_o}, {1'b0, es});
		chk("direct", direct_addr_o, {es[6:5], ad[6:0]});
		chk("indirect", indirect_addr_o, {es[7], seed[15:8]});
		if (rv) chk("result", {1'b0, result_o}, {1'b0, er});
		if (pc) chk("tmr_inc", {8'h00, tmr_inc_o}, {8'h00, tk});
		else chk("wdt_inc", {8'h00, wdt_inc_o}, {8'h00, wk});
		if (pc) chk("wdt_div", {8'h00, wdt_inc_o}, {8'h00, pe});
		else chk("tmr_div", {8'h00, tmr_inc_o}, {8'h00, pe});
		chk("file_we", {8'h00, file_we_o}, {8'h00, fe});
		chk("w_we", {8'h00, w_we_o}, {8'h00, we});
		v = alu(op, ad[6:0] == 7'h03 ? es : fr, w, b, es[0]);
		n = es;
		rv = op inside {[asb_pkg::ASB_ADD:asb_pkg::ASB_MOVE_W_TO_FILE_OP]};
		er = v[7:0];
		fe = rv && tf && ad[6:0] != 7'h03 && ad[7:0] != 8'h81;
		we = rv && !tf;
		if (tf && rv && ad[6:0] == 7'h03) n = {v[7:5], es[4:3], v[2:0]};
		if (tf && op == asb_pkg::ASB_FILE_CLEAR_OP && ad[6:0] == 7'h03) n[1:0] = es[1:0];
		if (v[13]) n[2] = v[10];
		if (v[12]) n[1] = v[9];
		if (v[11]) n[0] = v[8];
		if (op == asb_pkg::ASB_CLRWDT) n[4:3] = 2'b11;
		if (op == asb_pkg::ASB_SLEEP) n[4:3] = 2'b10;
		if (to) n[4] = 1'b0;
		es = n;
		tk = seed[16];
		wk = seed[17];
		pc = ps;
		pe = (pc ? seed[17] : seed[16]) &&
			(pn + 1) % (1 << (int'(rt) + int'(!pc))) == 0;
		if (pc ? seed[17] : seed[16]) pn++;
		if (tf && op == asb_pkg::ASB_MOVE_W_TO_FILE_OP && ad[7:0] == 8'h81) begin
			ps = w[3];
			rt = w[2:0];
		end
	endtask

	task automatic dir(input asb_pkg::asb_op_t op, input logic [8:0] ad,
		input logic [7:0] w, input logic [7:0] fr, input logic to);
		step(op, ad, 1'b1, w, fr, 3'h5, to);
	endtask

	task automatic rand_steps(input int cnt);
		asb_pkg::asb_op_t op;
		logic [8:0] ad;
		for (int i = 0; i < cnt; i++) begin
			seed = lfsr(seed);
			op = asb_pkg::asb_op_t'(4'(seed[7:0] % 15));
			ad = seed[8] ? {seed[10:9], 7'h03} : seed[20:12];
			if (ad[7:0] == 8'h81) ad[0] = 1'b0;
			step(op, ad, seed[11] | (op >= asb_pkg::ASB_FILE_CLEAR_OP), seed[31:24],
				seed[23:16], seed[2:0], 1'b0);
		end
	endtask

	initial begin
		repeat (100000) @(posedge clk_i);
		failures++;
		final_report();
	end

	initial begin
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		#1;
		chk("status", {1'b0, status_o}, 9'h018);
		chk("option", {1'b0, option_o}, 9'h0ff);
		$display("test done: reset");
		for (int i = 0; i < 15; i++) begin
			step(asb_pkg::asb_op_t'(4'(i)), {i[1:0], 7'h03}, 1'b1, 8'h96,
				8'h00, 3'(i), 1'b0);
		end
		dir(asb_pkg::ASB_MOVE_W_TO_FILE_OP, 9'h003, 8'he3, 8'h00, 1'b0);
		dir(asb_pkg::ASB_FILE_CLEAR_OP, 9'h183, 8'h00, 8'h00, 1'b0);
		dir(asb_pkg::ASB_MOVE_W_TO_FILE_OP, 9'h103, 8'hff, 8'h00, 1'b0);
		dir(asb_pkg::ASB_ADD, 9'h083, 8'h01, 8'h00, 1'b0);
		dir(asb_pkg::ASB_SUB, 9'h020, 8'h01, 8'h00, 1'b0);
		dir(asb_pkg::ASB_SUB, 9'h020, 8'h3c, 8'h3c, 1'b0);
		dir(asb_pkg::ASB_ADD, 9'h020, 8'h0f, 8'hf1, 1'b0);
		dir(asb_pkg::ASB_SLEEP, 9'h000, 8'h00, 8'h00, 1'b0);
		dir(asb_pkg::ASB_CLRWDT, 9'h000, 8'h00, 8'h00, 1'b1);
		dir(asb_pkg::ASB_CLRWDT, 9'h000, 8'h00, 8'h00, 1'b0);
		dir(asb_pkg::ASB_BSF, 9'h003, 8'h00, 8'h00, 1'b0);
		dir(asb_pkg::ASB_NOP, 9'h000, 8'h00, 8'h00, 1'b0);
		$display("test done: directed");
		rand_steps(300);
		$display("test done: random with prescaler on watchdog");
		dir(asb_pkg::ASB_MOVE_W_TO_FILE_OP, 9'h181, 8'h00, 8'h00, 1'b0);
		dir(asb_pkg::ASB_NOP, 9'h000, 8'h00, 8'h00, 1'b0);
		chk("option", {1'b0, option_o}, 9'h000);
		rand_steps(200);
		dir(asb_pkg::ASB_NOP, 9'h000, 8'h00, 8'h00, 1'b0);
		$display("test done: random with prescaler on timer");
		final_report();
	end
endmodule
`default_nettype wire
